// file: rtl/acl_edge_if.sv
/*
 * Link edge bundle: bit clock edges and data input, system clock domain.
 * Assumes the producer has already synchronised every signal.
 */
`timescale 1ns/1ns
`default_nettype none
interface acl_edge_if;
	logic bclk_rise; // One-cycle pulse on a bit clock rising edge
	logic bclk_fall; // One-cycle pulse on a bit clock falling edge
	logic sdin; // Synchronised serial input
	modport src (output bclk_rise, output bclk_fall, output sdin);
	modport dst (input bclk_rise, input bclk_fall, input sdin);
endinterface : acl_edge_if
`default_nettype wire

// file: rtl/acl_link_top.sv
/*
 * AC-link control slot engine with a classic Wishbone register slave.
 * Assumes an external codec supplying the bit clock, sampled here by
 * the system clock; bit clock must be far slower than the system clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "acl_params.svh"

// Operation
// - Captured read data sets read-done; CPU read clears
// - Tag write sets pending; cleared after shift-out
// - Tag writes ignored while write is pending
// - Warm bit forces sync high, then self-clears
// - Warm sync high lasts at least 10 us
// - Cold bit drives codec reset low
// - Control bit 5 enables bit clock pull-up
// - Slot 0 tags sent from tag register
// - Command bit 7 selects read or write
// - Command bits 6:0 carry codec index
// - Data register holds 16-bit write data
// - Input slot 0 captured into tag register
// - Echoed index captured into bits 8:2
// - Slot requests captured into bits 1:0
// - Read data captured into input data register
module acl_link_top (
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [31:0] WB_ADR_I,
	input wire acl_pkg::acl_word_t WB_DAT_I,
	input wire logic [3:0] WB_SEL_I,
	output var acl_pkg::acl_word_t WB_DAT_O,
	output logic WB_ACK_O,
	output logic IRQ,
	input wire logic LINK_BIT_CLOCK_IN,
	input wire logic LINK_SDATA_IN,
	output logic LINK_SDATA_OUT,
	output logic FRAME_SYNC_OUT,
	output logic CODEC_RESET_N_OUT,
	output logic BITCLK_PULLUP_ENABLE
);
	import acl_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	// Control register bits
	logic pullup_r; // Bit clock pull-up enable
	logic warm_r; // Warm reset in progress
	logic cold_r; // Cold reset asserted
	logic wpend_r; // Command waiting for a frame
	logic rdone_r; // Read data waiting for the CPU
	// Output slot registers
	logic [4:0] out_tag_r; // Frame valid and slot 1..4 valid
	logic [7:0] out_cmd_r; // Read select and codec index
	logic [15:0] out_data_r; // Write data for the codec
	// Input slot registers
	logic [4:0] in_tag_r; // Codec ready and slot valid bits
	logic [8:0] in_addr_r; // Echoed index and slot requests
	logic [15:0] in_data_r; // Codec read data
	// Interrupt registers
	logic [2:0] irq_st_r; // Sticky events
	logic [2:0] irq_mask_r; // Event enables
	logic [2:0] irq_set; // Events of this cycle
	// Bus slave
	logic ack_r; // Answer strobe
	acl_word_t dat_r; // Read data held with the answer
	acl_word_t rd_word; // Selected read value
	// Link state
	logic [7:0] bit_idx_r; // Bit now on the wire, 0..255
	logic [7:0] next_idx; // Bit started by a rising edge
	logic [55:0] out_shift_r; // Slots 0..2 waiting to go out
	logic [55:0] in_shift_r; // Slots 0..2 coming in
	logic [55:0] out_vec; // Frame image loaded at frame start
	logic [55:0] in_vec; // Input image completed at last bit
	logic sdo_r; // Serial output flop
	logic sync_r; // Frame sync from bit timing
	logic fsync_r; // Frame sync pin flop
	logic frame_cmd_r; // This frame carries the command
	logic frame_read_r; // This frame carries a read request
	logic read_expect_r; // Last frame asked for read data
	// Warm reset timer
	logic warm_start; // Software starts the warm reset
	logic warm_done; // Warm window has ended

	acl_edge_if link_edges ();

	// ****************************************
	// Helper functions
	// ****************************************
	// Byte lane merge of a write into a register value
	function automatic acl_word_t lane_merge(input acl_word_t old_v,
		input acl_word_t new_v, input logic [3:0] sel);
		acl_word_t res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : lane_merge

	// Sticky set over write-one clear; the set wins
	function automatic logic [2:0] sticky(input logic [2:0] cur,
		input logic [2:0] set, input logic [2:0] clr);
		return (cur & ~clr) | set;
	endfunction : sticky

	// ****************************************
	// Pin synchronisers and warm timer
	// ****************************************
	acl_sync u_sync (
		.clk(CLOCK),
		.rst_b(RST_B),
		.link_bclk(LINK_BIT_CLOCK_IN),
		.link_sdin(LINK_SDATA_IN),
		.edges(link_edges.src)
	);

	acl_warm u_warm (
		.clk(CLOCK),
		.rst_b(RST_B),
		.start(warm_start),
		.done(warm_done)
	);

	// ****************************************
	// Bus decode
	// ****************************************
	wire bus_req = WB_CYC_I & WB_STB_I & ~ack_r; // New request
	wire wr_en = bus_req & WB_WE_I; // Write taken
	wire rd_en = bus_req & ~WB_WE_I; // Read taken
	wire hit_ctrl = (WB_ADR_I == `ACL_ADR_CTRL);
	wire hit_otag = (WB_ADR_I == `ACL_ADR_OUT_TAG);
	wire hit_ocmd = (WB_ADR_I == `ACL_ADR_OUT_CMD);
	wire hit_odat = (WB_ADR_I == `ACL_ADR_OUT_DATA);
	wire hit_itag = (WB_ADR_I == `ACL_ADR_IN_TAG);
	wire hit_iadr = (WB_ADR_I == `ACL_ADR_IN_ADDR);
	wire hit_idat = (WB_ADR_I == `ACL_ADR_IN_DATA);
	wire hit_ist = (WB_ADR_I == `ACL_ADR_IRQ_ST);
	wire hit_imsk = (WB_ADR_I == `ACL_ADR_IRQ_MASK);

	// Merged write values, low lanes only matter
	wire acl_word_t wr_ctrl = lane_merge(32'h00000000, WB_DAT_I,
		WB_SEL_I);
	wire acl_word_t wr_ocmd = lane_merge({24'h000000, out_cmd_r},
		WB_DAT_I, WB_SEL_I);
	wire acl_word_t wr_odat = lane_merge({16'h0000, out_data_r},
		WB_DAT_I, WB_SEL_I);
	wire acl_word_t wr_otag = lane_merge({27'h0000000, out_tag_r},
		WB_DAT_I, WB_SEL_I);
	wire acl_word_t wr_imsk = lane_merge({29'h00000000, irq_mask_r},
		WB_DAT_I, WB_SEL_I);
	wire ctl_lane = wr_en & hit_ctrl & WB_SEL_I[0]; // Control write

	// Tag write only lands while no command is pending
	wire tag_write = wr_en & hit_otag & ~wpend_r;
	// Reading the data register hands it to the CPU
	wire data_read = rd_en & hit_idat;
	// Warm reset started by writing a one while idle
	assign warm_start = ctl_lane & wr_ctrl[`ACL_CTL_WARM] & ~warm_r;

	// Read selection; unmapped addresses read zero
	assign rd_word =
		hit_ctrl ? {26'h0000000, pullup_r, rdone_r, wpend_r, warm_r,
			cold_r, 1'b0} :
		hit_otag ? {27'h0000000, out_tag_r} :
		hit_ocmd ? {24'h000000, out_cmd_r} :
		hit_odat ? {16'h0000, out_data_r} :
		hit_itag ? {27'h0000000, in_tag_r} :
		hit_iadr ? {23'h000000, in_addr_r} :
		hit_idat ? {16'h0000, in_data_r} :
		hit_ist ? {29'h00000000, irq_st_r} :
		hit_imsk ? {29'h00000000, irq_mask_r} : 32'h00000000;

	// ****************************************
	// Link frame decode
	// ****************************************
	wire rise = link_edges.bclk_rise; // Bit clock rose
	wire fall = link_edges.bclk_fall; // Bit clock fell
	assign next_idx = bit_idx_r + 8'h01;
	wire frame_start = rise & (next_idx == 8'h00);
	// Input slots 0..2 complete on the fall of their last bit
	wire in_done = fall & (bit_idx_r == `ACL_IN_LAST_BIT);
	assign in_vec = {in_shift_r[54:0], link_edges.sdin};
	wire [15:0] in_s0 = in_vec[55:40]; // Input slot 0
	wire [19:0] in_s1 = in_vec[39:20]; // Input slot 1
	wire [19:0] in_s2 = in_vec[19:0]; // Input slot 2

	// Slot 0 tags go out only with a pending command
	wire [15:0] out_s0 = wpend_r ? {out_tag_r, 11'h000} : 16'h0000;
	// Slot images: command, then data, in slot order
	assign out_vec = {out_s0, out_cmd_r, 12'h000, out_data_r, 4'h0};

	// Read data arrives in the frame after the request
	wire rd_capture = in_done & read_expect_r & in_s0[13];
	// Command leaves the wire at the end of slot 2
	wire cmd_sent = in_done & frame_cmd_r;
	// Codec ready first seen
	wire ready_rise = in_done & in_s0[15] & ~in_tag_r[4];

	assign irq_set = {ready_rise, rd_capture, cmd_sent};

	// ****************************************
	// Bus answer
	// ****************************************
	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			ack_r <= 1'b0;
			dat_r <= 32'h00000000;
		end else begin
			ack_r <= bus_req;
			dat_r <= rd_en ? rd_word : 32'h00000000;
		end
	end

	// ****************************************
	// Control register
	// ****************************************
	// Flags set by hardware win over clears in the same cycle
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			pullup_r <= 1'b0;
			cold_r <= 1'b0;
			warm_r <= 1'b0;
			wpend_r <= 1'b0;
			rdone_r <= 1'b0;
		end else begin
			if (ctl_lane) begin
				pullup_r <= wr_ctrl[`ACL_CTL_PULLUP];
				cold_r <= wr_ctrl[`ACL_CTL_COLD];
			end
			// Warm bit clears itself when the window ends
			if (warm_start) begin
				warm_r <= 1'b1;
			end else if (warm_done) begin
				warm_r <= 1'b0;
			end
			// Pending from tag write until shifted out
			if (tag_write) begin
				wpend_r <= 1'b1;
			end else if (cmd_sent) begin
				wpend_r <= 1'b0;
			end
			// Read-done until the CPU reads the data
			if (rd_capture) begin
				rdone_r <= 1'b1;
			end else if (data_read) begin
				rdone_r <= 1'b0;
			end
		end
	end

	// ****************************************
	// Output slot registers
	// ****************************************
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			out_tag_r <= 5'h00;
			out_cmd_r <= `ACL_RST_OUT_CMD;
			out_data_r <= 16'h0000;
		end else begin
			if (tag_write) begin
				out_tag_r <= wr_otag[4:0];
			end
			if (wr_en & hit_ocmd) begin
				out_cmd_r <= wr_ocmd[7:0];
			end
			if (wr_en & hit_odat) begin
				out_data_r <= wr_odat[15:0];
			end
		end
	end

	// ****************************************
	// Input slot registers
	// ****************************************
	// Tag and status captured every frame; data only when expected
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			in_tag_r <= 5'h00;
			in_addr_r <= 9'h000;
			in_data_r <= 16'h0000;
		end else begin
			if (in_done) begin
				in_tag_r <= in_s0[15:11];
				in_addr_r <= {in_s1[18:12],
					in_s1[11:10]};
			end
			if (rd_capture) begin
				in_data_r <= in_s2[19:4];
			end
		end
	end

	// ****************************************
	// Interrupt registers
	// ****************************************
	// Status is write-one-clear; mask is plain read/write
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			irq_st_r <= 3'h0;
			irq_mask_r <= 3'h0;
		end else begin
			irq_st_r <= sticky(irq_st_r, irq_set,
				(wr_en & hit_ist & WB_SEL_I[0]) ? WB_DAT_I[2:0] : 3'h0);
			if (wr_en & hit_imsk) begin
				irq_mask_r <= wr_imsk[2:0];
			end
		end
	end

	// ****************************************
	// Frame transmit
	// ****************************************
	// New bit driven on each rising edge; codec samples on the fall
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			bit_idx_r <= `ACL_RST_BIT_IDX;
			out_shift_r <= 56'h00000000000000;
			sdo_r <= 1'b0;
			sync_r <= 1'b0;
			frame_cmd_r <= 1'b0;
			frame_read_r <= 1'b0;
			read_expect_r <= 1'b0;
		end else if (rise) begin
			bit_idx_r <= next_idx;
			sync_r <= (next_idx < `ACL_SYNC_BITS);
			if (frame_start) begin
				// Slots 0..2 go out back to back in one frame
				sdo_r <= out_vec[55];
				out_shift_r <= {out_vec[54:0], 1'b0};
				frame_cmd_r <= wpend_r;
				frame_read_r <= wpend_r & out_tag_r[0]
					& out_cmd_r[`ACL_CMD_READ];
				read_expect_r <= frame_read_r;
			end else begin
				sdo_r <= out_shift_r[55];
				out_shift_r <= {out_shift_r[54:0], 1'b0};
			end
		end
	end

	// ****************************************
	// Frame receive
	// ****************************************
	// Codec data is sampled on the falling edge
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			in_shift_r <= 56'h00000000000000;
		end else if (fall) begin
			in_shift_r <= in_vec;
		end
	end

	// ****************************************
	// Pin drivers
	// ****************************************
	// Warm reset overrides bit timing on the sync pin
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			fsync_r <= 1'b0;
		end else begin
			fsync_r <= warm_r | sync_r;
		end
	end

	assign FRAME_SYNC_OUT = fsync_r;
	assign LINK_SDATA_OUT = sdo_r;
	assign CODEC_RESET_N_OUT = ~cold_r;
	assign BITCLK_PULLUP_ENABLE = pullup_r;
	assign IRQ = |(irq_st_r & irq_mask_r);
	assign WB_ACK_O = ack_r;
	assign WB_DAT_O = dat_r;
endmodule : acl_link_top
`default_nettype wire

// file: rtl/acl_params.svh
/*
 * Constants of the AC-link control block: addresses, fields, resets, timing.
 * Assumes a 32-bit Wishbone address space and a 125 MHz system clock.
 */
`ifndef ACL_PARAMS_SVH
`define ACL_PARAMS_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define ACL_ADR_CTRL 32'hFFF0902C
`define ACL_ADR_OUT_TAG 32'hFFF09030
`define ACL_ADR_OUT_CMD 32'hFFF09034
`define ACL_ADR_OUT_DATA 32'hFFF09038
`define ACL_ADR_IN_TAG 32'hFFF0903C
`define ACL_ADR_IN_ADDR 32'hFFF09040
`define ACL_ADR_IN_DATA 32'hFFF09044
`define ACL_ADR_IRQ_ST 32'hFFF09048
`define ACL_ADR_IRQ_MASK 32'hFFF0904C

// ****************************************
// Control and command register fields
// ****************************************
`define ACL_CTL_COLD 1
`define ACL_CTL_WARM 2
`define ACL_CTL_WPEND 3
`define ACL_CTL_RDONE 4
`define ACL_CTL_PULLUP 5
`define ACL_CMD_READ 7

// ****************************************
// Reset values
// ****************************************
`define ACL_RST_OUT_CMD 8'h80
`define ACL_RST_BIT_IDX 8'hFF

// ****************************************
// Frame layout, in bit positions
// ****************************************
`define ACL_IN_LAST_BIT 8'h37
`define ACL_SYNC_BITS 8'h10

// ****************************************
// Timing
// ****************************************
`define ACL_CLK_PERIOD_NS 8
`define ACL_WARM_NS 10000
`define ACL_WARM_CYC ((`ACL_WARM_NS + `ACL_CLK_PERIOD_NS - 1) / `ACL_CLK_PERIOD_NS)

`endif

// file: rtl/acl_pkg.sv
/*
 * Types shared by the AC-link control block.
 * Assumes acl_params.svh carries the numeric constants.
 */
package acl_pkg;
	// Bus data word
	typedef logic [31:0] acl_word_t;
	// Warm reset timer states
	typedef enum logic [0:0] {
		WARM_IDLE,
		WARM_RUN
	} acl_warm_state_t;
endpackage : acl_pkg

// file: rtl/acl_sync.sv
/*
 * Two-flop synchronisers for the link pins, with bit clock edge detection.
 * Assumes the bit clock is well below half the system clock rate.
 */
`timescale 1ns/1ns
`default_nettype none
module acl_sync (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic link_bclk,
	input wire logic link_sdin,
	acl_edge_if.src edges
);
	logic bclk_s1_r; // First stage, read only by second
	logic bclk_s2_r; // Safe bit clock level
	logic bclk_s3_r; // Delayed level for edge detection
	logic sdin_s1_r; // First stage, read only by second
	logic sdin_s2_r; // Safe data level

	// ****************************************
	// Synchroniser chains
	// ****************************************
	// Data is delayed like the clock so edge and bit stay aligned
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bclk_s1_r <= 1'b0;
			bclk_s2_r <= 1'b0;
			bclk_s3_r <= 1'b0;
			sdin_s1_r <= 1'b0;
			sdin_s2_r <= 1'b0;
		end else begin
			bclk_s1_r <= link_bclk;
			bclk_s2_r <= bclk_s1_r;
			bclk_s3_r <= bclk_s2_r;
			sdin_s1_r <= link_sdin;
			sdin_s2_r <= sdin_s1_r;
		end
	end

	// Edge pulses from the safe stages only
	assign edges.bclk_rise = bclk_s2_r & ~bclk_s3_r;
	assign edges.bclk_fall = ~bclk_s2_r & bclk_s3_r;
	assign edges.sdin = sdin_s2_r;
endmodule : acl_sync
`default_nettype wire

// file: rtl/acl_warm.sv
/*
 * Warm reset timer: one start pulse opens a window of fixed length.
 * Assumes start arrives only while the timer is idle.
 */
`timescale 1ns/1ns
`default_nettype none
`include "acl_params.svh"
module acl_warm (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	output logic done
);
	import acl_pkg::*;

	localparam logic [10:0] WARM_LAST = 11'(`ACL_WARM_CYC - 1);

	acl_warm_state_t state_r; // Timer state
	acl_warm_state_t state_nxt;
	logic [10:0] cnt_r; // Cycles spent in the window
	logic [10:0] cnt_nxt;
	logic at_end; // Window has reached its length

	assign at_end = (cnt_r == WARM_LAST);
	assign done = (state_r == WARM_RUN) & at_end;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		unique case (state_r)
			WARM_IDLE: begin
				cnt_nxt = 11'h000;
				if (start) begin
					state_nxt = WARM_RUN;
				end
			end
			WARM_RUN: begin
				// Holds sync high long enough for the codec
				if (at_end) begin
					state_nxt = WARM_IDLE;
				end else begin
					cnt_nxt = cnt_r + 11'h001;
				end
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= WARM_IDLE;
			cnt_r <= 11'h000;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule : acl_warm
`default_nettype wire

// file: tb/ac_link_control_slots_tb.sv
/* Self-checking bench for the link control slot block.
   Assumes the codec model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
`include "acl_params.svh"
module ac_link_control_slots_tb;
	import acl_pkg::*;
	// ****
	// Signals
	// ****
	logic clk, rst_b, cyc, stb, we, ack, irq, sdin, sdout, sync;
	logic rst_n_o, pull, bclk, run, chk, sync_bad, ftgl;
	logic [31:0] adr; // Bus address
	acl_word_t wdat, rdat, dat_o; // Bus data
	logic [4:0] m_tag; // Codec slot contents
	logic [6:0] m_idx, idx;
	logic [1:0] m_req;
	logic [15:0] m_rd, wd, rv;
	logic [55:0] frame;
	logic [63:0] nt, q_rd[$]; // Expected read word and mask
	logic [55:0] q_fr[$]; // Expected command frames
	int n_fail, n_compared;
	localparam logic [31:0] reg_adr [10] = '{`ACL_ADR_CTRL,
		`ACL_ADR_OUT_TAG, `ACL_ADR_OUT_CMD, `ACL_ADR_OUT_DATA,
		`ACL_ADR_IN_TAG, `ACL_ADR_IN_ADDR, `ACL_ADR_IN_DATA,
		`ACL_ADR_IRQ_ST, `ACL_ADR_IRQ_MASK, 32'hFFF09050};
	localparam logic [31:0] reg_rst [10] = '{32'h0, 32'h0, 32'h80,
		32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
	acl_link_top i_dut (.CLOCK(clk), .RST_B(rst_b), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(wdat),
		.WB_SEL_I(4'hF), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .IRQ(irq),
		.LINK_BIT_CLOCK_IN(bclk), .LINK_SDATA_IN(sdin),
		.LINK_SDATA_OUT(sdout), .FRAME_SYNC_OUT(sync),
		.CODEC_RESET_N_OUT(rst_n_o), .BITCLK_PULLUP_ENABLE(pull));
	acl_codec_model i_codec (.run(run), .chk(chk), .sync(sync),
		.sdout(sdout), .tag(m_tag), .idx(m_idx), .req(m_req),
		.rdat(m_rd), .bclk(bclk), .sdin(sdin), .sync_bad(sync_bad),
		.frame(frame), .ftgl(ftgl));
	// ****
	// Tasks
	// ****
	task automatic cmp_w(input logic [31:0] got, exp, msk);
		n_compared++;
		if ((got & msk) !== (exp & msk)) begin
			n_fail++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_w
	task automatic cmp_f(input logic [55:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_f
	// One classic cycle; hold all until ack is sampled
	task automatic bus(input logic w, input logic [31:0] a, d);
		int k;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		if (k >= 50) n_fail++;
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus
	task automatic wr(input logic [31:0] a, d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [31:0] a, e, m);
		q_rd.push_back({e, m});
		bus(1'b0, a, 32'h0);
	endtask : rd
	// Bounded wait on a control bit
	task automatic poll(input int b, input logic v);
		int k;
		k = 0;
		do begin
			rd(`ACL_ADR_CTRL, 32'h0, 32'h0);
			k++;
		end while (rdat[b] !== v && k < 12000);
		if (k >= 12000) n_fail++;
	endtask : poll
	task automatic complete_run();
		if (n_fail == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	// ****
	// Monitors, clock, watchdog
	// ****
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0) begin
			nt = q_rd.pop_front();
			cmp_w(dat_o, nt[63:32], nt[31:0]);
		end
	end
	// Only frames carrying a tag slot are noted
	always @(ftgl) begin
		if (run === 1'b1 && frame[55:40] !== 16'h0)
			cmp_f(frame, q_fr.size() > 0 ? q_fr.pop_front() : 56'h0);
	end
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		#600000;
		n_fail++;
		complete_run();
	end
	// ****
	// Scenarios
	// ****
	initial begin
		{rst_b, cyc, stb, we, run, chk} = 6'h0;
		adr = 32'h0;
		wdat = 32'h0;
		{m_tag, m_idx, m_req, m_rd} = {5'h1F, 7'h0, 2'h2, 16'h0};
		void'($urandom(55));
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		cmp_w({irq, rst_n_o, pull}, 32'h2, 32'h7);
		// Read-only and unmapped writes are dropped
		wr(`ACL_ADR_IN_DATA, 32'hFFFFFFFF);
		wr(32'hFFF09050, 32'hFFFFFFFF);
		for (int i = 0; i < 10; i++) rd(reg_adr[i], reg_rst[i], '1);
		wr(`ACL_ADR_CTRL, 32'h22);
		rd(`ACL_ADR_CTRL, 32'h22, 32'h26);
		cmp_w(rst_n_o, 1'b0, 32'h1);
		cmp_w(pull, 1'b1, 32'h1);
		repeat (1250) @(posedge clk);
		wr(`ACL_ADR_CTRL, 32'h0);
		@(posedge clk);
		cmp_w({rst_n_o, pull}, 32'h2, 32'h3);
		// Codec write command over the link
		run <= 1'b1;
		chk <= 1'b1;
		idx = 7'($urandom);
		wd = 16'($urandom);
		wr(`ACL_ADR_IRQ_MASK, 32'h1);
		wr(`ACL_ADR_OUT_CMD, {25'h0, idx});
		wr(`ACL_ADR_OUT_DATA, {16'h0, wd});
		rd(`ACL_ADR_OUT_CMD, {25'h0, idx}, 32'hFF);
		rd(`ACL_ADR_OUT_DATA, {16'h0, wd}, '1);
		q_fr.push_back({16'h8800, 1'b0, idx, 12'h0, wd, 4'h0});
		wr(`ACL_ADR_OUT_TAG, 32'h11);
		rd(`ACL_ADR_CTRL, 32'h8, 32'h8);
		wr(`ACL_ADR_OUT_TAG, 32'h1F);
		rd(`ACL_ADR_OUT_TAG, 32'h11, '1);
		poll(3, 1'b0);
		// Send event: raise, mask, clear
		rd(`ACL_ADR_IRQ_ST, 32'h5, 32'h7);
		cmp_w(irq, 1'b1, 32'h1);
		wr(`ACL_ADR_IRQ_MASK, 32'h0);
		@(posedge clk);
		cmp_w(irq, 1'b0, 32'h1);
		wr(`ACL_ADR_IRQ_ST, 32'h1);
		wr(`ACL_ADR_IRQ_MASK, 32'h1);
		@(posedge clk);
		cmp_w(irq, 1'b0, 32'h1);
		// Codec register read, data a frame later
		idx = 7'($urandom);
		rv = 16'($urandom);
		m_idx <= idx;
		m_rd <= rv;
		wr(`ACL_ADR_OUT_CMD, {24'h0, 1'b1, idx});
		q_fr.push_back({16'h9800, 1'b1, idx, 12'h0, wd, 4'h0});
		wr(`ACL_ADR_OUT_TAG, 32'h13);
		poll(4, 1'b1);
		rd(`ACL_ADR_IN_TAG, 32'h1F, '1);
		rd(`ACL_ADR_IN_ADDR, {23'h0, idx, 2'h2}, '1);
		rd(`ACL_ADR_IN_DATA, {16'h0, rv}, '1);
		rd(`ACL_ADR_CTRL, 32'h0, 32'h10);
		rd(`ACL_ADR_IRQ_ST, 32'h7, 32'h7);
		// Warm reset, then sync back on frame timing
		chk <= 1'b0;
		wr(`ACL_ADR_CTRL, 32'h4);
		rd(`ACL_ADR_CTRL, 32'h4, 32'h4);
		cmp_w(sync, 1'b1, 32'h1);
		poll(2, 1'b0);
		repeat (40) @(posedge clk);
		chk <= 1'b1;
		repeat (6000) @(posedge clk);
		cmp_w({sync_bad, q_fr.size() == 0}, 32'h1, 32'h3);
		complete_run();
	end
endmodule : ac_link_control_slots_tb
`default_nettype wire

// file: tb/acl_codec_model.sv
/* Behavioural codec: bit clock, input slots 0..2, capture of out slots.
   Assumes the bench sets slot contents and starts the clock. */
`timescale 1ns/1ns
`default_nettype none
module acl_codec_model (
	input wire logic run,
	input wire logic chk,
	input wire logic sync,
	input wire logic sdout,
	input wire logic [4:0] tag,
	input wire logic [6:0] idx,
	input wire logic [1:0] req,
	input wire logic [15:0] rdat,
	output logic bclk,
	output logic sdin,
	output logic sync_bad,
	output logic [55:0] frame,
	output logic ftgl
);
	logic [7:0] bit_r; // Frame bit, FF before the first
	logic [55:0] sh_r; // Out slots 0..2 as seen
	wire [7:0] bit_nxt = bit_r + 8'h1;
	// Input slots 0..2, MSB first
	wire [55:0] img = {tag, 11'h0, 1'b0, idx, req, 10'h0, rdat, 4'h0};
	// Free bit clock, odd phase against the system clock
	initial begin
		bclk = 1'b0;
		bit_r = 8'hFF;
		sdin = 1'b0;
		sync_bad = 1'b0;
		ftgl = 1'b0;
		#3;
		forever begin
			#80;
			if (run) bclk = ~bclk;
		end
	end
	// Launch on rise, zeros past slot 2
	always @(posedge bclk) begin
		bit_r <= bit_nxt;
		sdin <= bit_nxt < 8'h38 ? img[8'h37 - bit_nxt] : 1'b0;
	end
	// Sample device on fall; sync high in bits 0..15 only
	always @(negedge bclk) begin
		if (bit_r < 8'h38) sh_r <= {sh_r[54:0], sdout};
		if (bit_r == 8'h37) begin
			frame <= {sh_r[54:0], sdout};
			ftgl <= ~ftgl;
		end
		if (chk && sync !== (bit_r < 8'h10)) sync_bad <= 1'b1;
	end
endmodule : acl_codec_model
`default_nettype wire

// file: tb/acl_link_sva.sv
/* Checker for the link top: bus answer, reset pins, warm window.
   Assumes it is bound to acl_link_top and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
`include "acl_params.svh"
module acl_link_sva (
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [31:0] WB_ADR_I,
	input wire acl_pkg::acl_word_t WB_DAT_I,
	input wire logic [3:0] WB_SEL_I,
	input wire acl_pkg::acl_word_t WB_DAT_O,
	input wire logic WB_ACK_O,
	input wire logic FRAME_SYNC_OUT,
	input wire logic CODEC_RESET_N_OUT,
	input wire logic BITCLK_PULLUP_ENABLE
);
	import acl_pkg::*;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_B);
	// ****
	// Helpers
	// ****
	// Control write taken this edge
	wire ctl_wr = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O
		&& WB_ADR_I == `ACL_ADR_CTRL && WB_SEL_I[0];
	logic [15:0] hi_r; // Sync high run length
	logic warm_r; // Warm window armed
	// Arming restarts the run count, so a frame sync pulse that ends
	// just as the warm write lands is not taken for a short window
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			hi_r <= 16'h0;
			warm_r <= 1'b0;
		end else if (ctl_wr && WB_DAT_I[2]) begin
			hi_r <= 16'h0;
			warm_r <= 1'b1;
		end else begin
			hi_r <= FRAME_SYNC_OUT ? hi_r + 16'h1 : 16'h0;
			// Short glitches must not disarm, so only a real run counts
			if (!FRAME_SYNC_OUT && hi_r > 16'h2) begin
				warm_r <= 1'b0;
			end
		end
	end
	// ****
	// Assertions
	// ****
	a_ack_one_pulse: assert property (
		WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
	a_ack_after_take: assert property (
		WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("no ack");
	a_ack_needs_req: assert property (
		$rose(WB_ACK_O) |-> $past(WB_CYC_I) && $past(WB_STB_I))
		else $error("ack unasked");
	a_dat_idle_zero: assert property (
		!WB_ACK_O |-> WB_DAT_O == '0) else $error("data idle");
	a_cold_drives_pin: assert property (
		ctl_wr |-> ##2 CODEC_RESET_N_OUT == !$past(WB_DAT_I[1], 2))
		else $error("codec reset pin");
	a_pullup_follows_bit: assert property (
		ctl_wr |-> ##2 BITCLK_PULLUP_ENABLE == $past(WB_DAT_I[5], 2))
		else $error("pull-up pin");
	a_warm_sync_rise: assert property (
		ctl_wr && WB_DAT_I[2] |-> ##[2:3] FRAME_SYNC_OUT)
		else $error("warm sync low");
	a_warm_sync_len: assert property (
		warm_r && hi_r > 16'h2 && !FRAME_SYNC_OUT
		|-> hi_r >= `ACL_WARM_CYC) else $error("warm too short");
endmodule : acl_link_sva
bind acl_link_top acl_link_sva i_sva (.CLOCK, .RST_B, .WB_CYC_I,
	.WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_I, .WB_SEL_I, .WB_DAT_O,
	.WB_ACK_O, .FRAME_SYNC_OUT, .CODEC_RESET_N_OUT, .BITCLK_PULLUP_ENABLE);
`default_nettype wire
